// ---- rtl/asl_pkg.sv ----
// asl_pkg: shared constants and types of the accumulator/stack load unit
// assumes: one clock domain, sequencer and variable memory on that clock
package asl_pkg;

    // datapath widths
    localparam int ACC_W   = 32;            // accumulator and stack entries
    localparam int WORD_W  = 16;            // one memory word
    localparam int ADDR_W  = 16;            // memory word index
    localparam int STK_DEP = 8;             // stack levels
    localparam int OCT_DIG = 6;             // octal digits of an address

    // field positions inside the accumulator
    localparam int LO_MSB  = 15;            // top bit of the low word
    localparam int HI_LSB  = 16;            // bottom bit of the high word
    localparam int SIGN_B  = 31;            // two's-complement sign bit

    // constants
    localparam logic [ACC_W-1:0]  ACC_RST  = 32'h0000_0000;
    localparam logic [WORD_W-1:0] HALF_0   = 16'h0000;
    localparam logic [WORD_W-1:0] IMM_MAX  = 16'hFFFF;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;

    // command codes from the sequencer
    typedef enum logic [2:0] {
        OP_LOAD_WORD       = 3'h0,      // 16-bit load, high half cleared
        OP_LOAD_DOUBLE     = 3'h1,      // 32-bit load, two words
        OP_LOAD_OCTAL_ADDR = 3'h2,      // octal address to binary, load
        OP_STORE_WORD      = 3'h3,      // low half to one word
        OP_STORE_DOUBLE    = 3'h4,      // 32 bits to two words
        OP_POP             = 3'h5,      // stack top into accumulator
        OP_RESULT          = 3'h6       // manipulation result into acc
    } asl_op_e;

    // operand addressing modes
    typedef enum logic [1:0] {
        MODE_IMM = 2'h0,                // constant on cmd_data
        MODE_DIR = 2'h1,                // cmd_addr names the word
        MODE_PTR = 2'h2                 // cmd_addr names the pointer word
    } asl_mode_e;

    // sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,                 // waiting for a command
        ST_PTR  = 4'h2,                 // reading the pointer word
        ST_LO   = 4'h4,                 // low word transfer
        ST_HI   = 4'h8                  // high word transfer
    } asl_state_e;

endpackage

// ---- rtl/asl_stack.sv ----
// asl_stack: push-down stack of accumulator words held in flip-flops
// assumes: push and pop never asserted together by the owner
module asl_stack
    import asl_pkg::*;
#(
    parameter int DEPTH = STK_DEP,      // number of levels
    parameter int W     = ACC_W         // entry width
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // control
    input  wire logic         push,
    input  wire logic         pop,
    input  wire logic [W-1:0] push_data,
    // view of the top level
    output logic [W-1:0]      top
);

    // a stack of one level could not shift at all
    if (DEPTH < 2) begin : g_chk
        $error("asl_stack: DEPTH must be at least 2");
    end

    logic [W-1:0] ent_q [DEPTH];        // index 0 is the top
    logic [W-1:0] ent_d [DEPTH];        // next contents

    // next contents: shift down on push, up on pop
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            ent_d[i] = ent_q[i];
        end
        if (push) begin
            // the bottom level falls off and is lost
            for (int i = DEPTH - 1; i > 0; i--) begin
                ent_d[i] = ent_q[i-1];
            end
            ent_d[0] = push_data;
        end else if (pop) begin
            // remaining levels move up, zero enters the bottom
            for (int i = 0; i < DEPTH - 1; i++) begin
                ent_d[i] = ent_q[i+1];
            end
            ent_d[DEPTH-1] = ACC_RST;
        end
    end

    // level registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                ent_q[i] <= ACC_RST;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                ent_q[i] <= ent_d[i];
            end
        end
    end

    assign top = ent_q[0];

endmodule

// ---- rtl/asl_oct_to_bin.sv ----
// asl_oct_to_bin: packs octal digits, one per nibble, into a binary value
// assumes: each nibble holds 0..7; a bigger nibble keeps its low 3 bits
module asl_oct_to_bin
    import asl_pkg::*;
#(
    parameter int DIGITS = OCT_DIG      // octal digits accepted
) (
    // digits, least significant in bits 3:0
    input  wire logic [4*DIGITS-1:0] digits,
    // binary equivalent
    output logic [3*DIGITS-1:0]      value
);

    if (DIGITS < 1 || 3 * DIGITS > ACC_W) begin : g_chk
        $error("asl_oct_to_bin: DIGITS out of range");
    end

    // each octal digit is exactly three binary bits
    for (genvar g = 0; g < DIGITS; g++) begin : g_dig
        assign value[3*g +: 3] = digits[4*g +: 3];
    end

endmodule

// ---- rtl/asl_unit.sv ----
// asl_unit: accumulator with push-down stack, loads, stores and pops
// assumes: sequencer and variable memory run on ref_clk; memory answers
// each request with a one-cycle mem_ack, read data valid with that ack

// Behaviour
// - 32-bit accumulator, cleared at every scan end
// - word load fills low half, zeroes high
// - word constant limited to 0 to FFFF
// - double load/store moves two consecutive words
// - later loads push previous accumulator first
// - store cancels the pending push
// - push shifts every stack entry down
// - eight 32-bit levels, bottom lost when full
// - pop moves top into accumulator, shifts up
// - pointer word holds binary index of target
// - octal address operand converted to binary
// - pointer outside memory sets range flag
// - negative flag follows accumulator sign
// - zero flag set when load gives zero
// - manipulation result replaces accumulator contents
module asl_unit
    import asl_pkg::*;
#(
    parameter int DEPTH = STK_DEP       // stack levels
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    // command from the sequencer
    input  wire logic              cmd_valid,
    input  wire logic [2:0]        cmd_op,
    input  wire logic [1:0]        cmd_mode,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic [ACC_W-1:0]  cmd_data,
    input  wire logic              scan_end,
    output logic                   cmd_ready_q,
    output logic                   cmd_done_q,
    // implemented memory window for pointers
    input  wire logic [ADDR_W-1:0] ptr_lo_bound,
    input  wire logic [ADDR_W-1:0] ptr_hi_bound,
    // variable memory port
    output logic                   mem_req_q,
    output logic                   mem_we_q,
    output logic [ADDR_W-1:0]      mem_addr_q,
    output logic [WORD_W-1:0]      mem_wdata_q,
    input  wire logic [WORD_W-1:0] mem_rdata,
    input  wire logic              mem_ack,
    // accumulator and flags
    output logic [ACC_W-1:0]       acc_q,
    output logic                   pointer_range_flag_q,
    output logic                   negative_flag_q,
    output logic                   zero_load_flag_q
);

    // reset release: asynchronous assert, two-flop release
    logic rst_s1_q;                     // first release stage
    logic rst_s2_q;                     // reset used by the design
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // sequencer state
    asl_state_e          state_q, state_d;
    asl_op_e             op_q, op_d;        // command in progress
    logic [ADDR_W-1:0]   base_q, base_d;    // resolved word index
    logic [WORD_W-1:0]   low_q, low_d;      // low word of a double load
    logic                pend_q, pend_d;    // next load must push
    logic [ACC_W-1:0]    acc_d;
    logic                ready_d, done_d;
    logic                req_d, we_d;
    logic [ADDR_W-1:0]   maddr_d;
    logic [WORD_W-1:0]   wdata_d;
    logic                prng_d, neg_d, zero_d;

    // stack control and view
    logic                push;
    logic                pop;
    logic [ACC_W-1:0]    stk_top;

    // octal address conversion of the low digits of cmd_data
    logic [3*OCT_DIG-1:0] oct_val;

    asl_stack #(
        .DEPTH     (DEPTH),
        .W         (ACC_W)
    ) u_stack (
        .clk       (ref_clk),
        .rst_n     (rst_s2_q),
        .push      (push),
        .pop       (pop),
        .push_data (acc_q),
        .top       (stk_top)
    );

    asl_oct_to_bin #(
        .DIGITS (OCT_DIG)
    ) u_oct (
        .digits (cmd_data[4*OCT_DIG-1:0]),
        .value  (oct_val)
    );

    // decoded command in the idle state
    asl_op_e   cop;
    asl_mode_e cmode;
    logic      take;
    assign cop   = asl_op_e'(cmd_op);
    assign cmode = asl_mode_e'(cmd_mode);
    assign take  = cmd_valid && cmd_ready_q;

    // is the operation in progress a store
    function automatic logic is_store(input asl_op_e o);
        is_store = (o == OP_STORE_WORD) || (o == OP_STORE_DOUBLE);
    endfunction

    // next values of the whole datapath
    always_comb begin
        state_d = state_q;
        op_d    = op_q;
        base_d  = base_q;
        low_d   = low_q;
        pend_d  = pend_q;
        acc_d   = acc_q;
        done_d  = 1'b0;
        push    = 1'b0;
        pop     = 1'b0;
        prng_d  = pointer_range_flag_q;
        zero_d  = zero_load_flag_q;

        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    op_d   = cop;
                    base_d = cmd_addr;
                    case (cop)
                        OP_POP: begin
                            // accumulator discarded, top moves
                            pop    = 1'b1;
                            acc_d  = stk_top;
                            done_d = 1'b1;
                        end
                        OP_RESULT: begin
                            // result overwrites, no push
                            acc_d  = cmd_data;
                            done_d = 1'b1;
                        end
                        OP_LOAD_OCTAL_ADDR: begin
                            // binary form of the octal operand
                            push   = pend_q;
                            acc_d  = ACC_W'(oct_val);
                            zero_d = (oct_val == '0);
                            pend_d = 1'b1;
                            done_d = 1'b1;
                        end
                        default: begin
                            if (cmode == MODE_PTR) begin
                                state_d = ST_PTR;
                            end else if (cmode == MODE_DIR) begin
                                state_d = ST_LO;
                            end else if (cop == OP_LOAD_WORD) begin
                                // constant is at most four hex digits
                                push   = pend_q;
                                acc_d  = {HALF_0,
                                          cmd_data[LO_MSB:0] & IMM_MAX};
                                zero_d = (acc_d == ACC_RST);
                                pend_d = 1'b1;
                                done_d = 1'b1;
                            end else if (cop == OP_LOAD_DOUBLE) begin
                                // eight-digit constant fills all 32 bits
                                push   = pend_q;
                                acc_d  = cmd_data;
                                zero_d = (cmd_data == ACC_RST);
                                pend_d = 1'b1;
                                done_d = 1'b1;
                            end else begin
                                // a constant cannot be stored into;
                                // the store still cancels the push
                                pend_d = 1'b0;
                                done_d = 1'b1;
                            end
                        end
                    endcase
                end
            end
            ST_PTR: begin
                if (mem_ack) begin
                    // pointer contents are a binary index
                    if (mem_rdata < ptr_lo_bound ||
                        mem_rdata > ptr_hi_bound) begin
                        // abandon the access, accumulator untouched
                        prng_d  = 1'b1;
                        done_d  = 1'b1;
                        state_d = ST_IDLE;
                    end else begin
                        prng_d  = 1'b0;
                        base_d  = mem_rdata;
                        state_d = ST_LO;
                    end
                end
            end
            ST_LO: begin
                if (mem_ack) begin
                    case (op_q)
                        OP_LOAD_WORD: begin
                            push    = pend_q;
                            acc_d   = {HALF_0, mem_rdata};
                            zero_d  = (mem_rdata == HALF_0);
                            pend_d  = 1'b1;
                            done_d  = 1'b1;
                            state_d = ST_IDLE;
                        end
                        OP_STORE_WORD: begin
                            pend_d  = 1'b0;
                            done_d  = 1'b1;
                            state_d = ST_IDLE;
                        end
                        default: begin
                            // first of two words of a double
                            low_d   = mem_rdata;
                            state_d = ST_HI;
                        end
                    endcase
                end
            end
            ST_HI: begin
                if (mem_ack) begin
                    if (op_q == OP_LOAD_DOUBLE) begin
                        push   = pend_q;
                        acc_d  = {mem_rdata, low_q};
                        zero_d = ({mem_rdata, low_q} == ACC_RST);
                        pend_d = 1'b1;
                    end else begin
                        pend_d = 1'b0;
                    end
                    done_d  = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase

        // scan end wins over state, accumulator, push, pop and flags: the next load is the first one
        if (scan_end) begin
            state_d = ST_IDLE;
            acc_d   = ACC_RST;
            pend_d  = 1'b0;
            prng_d  = 1'b0;
            zero_d  = 1'b0;
            push    = 1'b0;
            pop     = 1'b0;
        end

        // sign bit of the two's-complement value
        neg_d   = acc_d[SIGN_B];
        ready_d = (state_d == ST_IDLE);
    end

    // memory request for the state about to be entered; the request
    // stands until acknowledged or a scan end, so a slow memory simply stretches it
    always_comb begin
        req_d   = (state_d != ST_IDLE);
        we_d    = 1'b0;
        maddr_d = base_d;
        wdata_d = acc_d[LO_MSB:0];
        case (state_d)
            ST_PTR: begin
                maddr_d = base_d;
            end
            ST_LO: begin
                we_d    = is_store(op_d);
                maddr_d = base_d;
                wdata_d = acc_d[LO_MSB:0];
            end
            ST_HI: begin
                // second word sits at the next index
                we_d    = is_store(op_d);
                maddr_d = base_d + ADDR_ONE;
                wdata_d = acc_d[ACC_W-1:HI_LSB];
            end
            default: begin
                req_d = 1'b0;
            end
        endcase
    end

    // all state registers
    always_ff @(posedge ref_clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            state_q              <= ST_IDLE;
            op_q                 <= OP_LOAD_WORD;
            base_q               <= '0;
            low_q                <= HALF_0;
            pend_q               <= 1'b0;
            acc_q                <= ACC_RST;
            cmd_ready_q          <= 1'b0;
            cmd_done_q           <= 1'b0;
            mem_req_q            <= 1'b0;
            mem_we_q             <= 1'b0;
            mem_addr_q           <= '0;
            mem_wdata_q          <= HALF_0;
            pointer_range_flag_q <= 1'b0;
            negative_flag_q      <= 1'b0;
            zero_load_flag_q     <= 1'b0;
        end else begin
            state_q              <= state_d;
            op_q                 <= op_d;
            base_q               <= base_d;
            low_q                <= low_d;
            pend_q               <= pend_d;
            acc_q                <= acc_d;
            cmd_ready_q          <= ready_d;
            cmd_done_q           <= done_d;
            mem_req_q            <= req_d;
            mem_we_q             <= we_d;
            mem_addr_q           <= maddr_d;
            mem_wdata_q          <= wdata_d;
            pointer_range_flag_q <= prng_d;
            negative_flag_q      <= neg_d;
            zero_load_flag_q     <= zero_d;
        end
    end

endmodule

// ---- verification/asl_unit_chk.sv ----
// asl_unit_chk: port-level checks for the accumulator/stack unit
// assumes: bound onto asl_unit, one clock, rst_n low means reset
module asl_unit_chk
    import asl_pkg::*;
#(
    parameter int DEPTH = STK_DEP           // stack levels
) (
    // clock and reset
    input wire logic              ref_clk,
    input wire logic              rst_n,
    // command side
    input wire logic              cmd_valid,
    input wire logic [2:0]        cmd_op,
    input wire logic [1:0]        cmd_mode,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [ACC_W-1:0]  cmd_data,
    input wire logic              scan_end,
    input wire logic              cmd_ready_q,
    input wire logic              cmd_done_q,
    // memory side
    input wire logic              mem_req_q,
    input wire logic              mem_we_q,
    input wire logic [ADDR_W-1:0] mem_addr_q,
    input wire logic [WORD_W-1:0] mem_wdata_q,
    input wire logic              mem_ack,
    // results
    input wire logic [ACC_W-1:0]  acc_q,
    input wire logic              pointer_range_flag_q,
    input wire logic              negative_flag_q,
    input wire logic              zero_load_flag_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic take;                             // command accepted this edge
    assign take = cmd_valid && cmd_ready_q && !scan_end;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    neg_sign_a:
        assert property (negative_flag_q == acc_q[SIGN_B])
        else $error("negative flag differs from sign bit");
    imm_word_a:
        assert property (take && cmd_op == OP_LOAD_WORD && cmd_mode == MODE_IMM
            |=> acc_q == {HALF_0, $past(cmd_data[LO_MSB:0])} && cmd_done_q)
        else $error("word load result wrong");
    zero_load_a:
        assert property (take && cmd_op == OP_LOAD_WORD && cmd_mode == MODE_IMM
            && cmd_data[LO_MSB:0] == HALF_0 |=> zero_load_flag_q)
        else $error("zero flag missing after zero load");
    result_a:
        assert property (take && cmd_op == OP_RESULT
            |=> acc_q == $past(cmd_data))
        else $error("result not left in accumulator");
    octal_a:
        assert property (take && cmd_op == OP_LOAD_OCTAL_ADDR |=> acc_q ==
            {14'h0000, $past(cmd_data[22:20]), $past(cmd_data[18:16]),
            $past(cmd_data[14:12]), $past(cmd_data[10:8]),
            $past(cmd_data[6:4]), $past(cmd_data[2:0])})
        else $error("octal conversion wrong");
    scan_clr_a:
        assert property (scan_end |=> acc_q == ACC_RST && !zero_load_flag_q
            && !pointer_range_flag_q)
        else $error("scan end did not clear state");
    dbl_addr_a:
        assert property (take && cmd_mode == MODE_DIR && (cmd_op ==
            OP_LOAD_DOUBLE || cmd_op == OP_STORE_DOUBLE)
            |=> mem_req_q && mem_addr_q == $past(cmd_addr))
        else $error("first word address wrong");
    store_data_a:
        assert property (take && cmd_op == OP_STORE_DOUBLE && cmd_mode ==
            MODE_DIR |=> mem_we_q && mem_wdata_q == $past(acc_q[LO_MSB:0]))
        else $error("low word write data wrong");
    mem_hold_a:
        assert property (mem_req_q && !mem_ack && !scan_end
            |=> mem_req_q && $stable(mem_addr_q) && $stable(mem_we_q))
        else $error("memory request dropped or changed");
    dbl_done_a:
        assert property (disable iff (!rst_n || scan_end) take && cmd_op ==
            OP_LOAD_DOUBLE && cmd_mode == MODE_DIR |-> ##[2:60] cmd_done_q)
        else $error("double load never completed");
    // main scenarios reached
    cover property (take && cmd_op == OP_POP);
    cover property ($rose(pointer_range_flag_q));
    cover property (mem_req_q && mem_ack && mem_we_q);
endmodule

// ---- verification/asl_mem_model.sv ----
// asl_mem_model: variable memory answering the unit's word requests
// assumes: one request at a time, held by the unit until the ack
module asl_mem_model
    import asl_pkg::*;
(
    // clock
    input  wire logic              clk,
    // request side
    input  wire logic              req,
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [WORD_W-1:0] wdata,
    input  wire logic [3:0]        lat,
    // answer side
    output logic [WORD_W-1:0]      rdata,
    output logic                   ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [WORD_W-1:0] mem [256];           // only low 8 address bits decode
    logic [3:0]        wait_q = 4'h0;       // cycles already waited
    initial ack = 1'b0;
    initial rdata = 16'h0000;
    // rdata toggles outside the ack so a late sample never matches by luck
    always @(posedge clk) begin
        ack <= 1'b0;
        rdata <= ~rdata;
        if (req && !ack && wait_q >= lat) begin
            ack <= 1'b1;
            wait_q <= 4'h0;
            if (we)
                mem[addr[7:0]] <= wdata;
            else
                rdata <= mem[addr[7:0]];
        end else if (req && !ack) begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule

// ---- verification/asl_unit_tb_top.sv ----
// asl_unit_tb_top: directed bench for the accumulator/stack unit
// assumes: memory model as far side, checker bound onto the unit
module asl_unit_tb_top
    import asl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEPTH = 8;               // stack levels under test
    logic ref_clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, scan_end = 1'b0;
    logic [2:0]        cmd_op = 3'h7;
    logic [1:0]        cmd_mode = 2'h0;
    logic [ADDR_W-1:0] cmd_addr = 16'h0000;
    logic [ACC_W-1:0]  cmd_data = 32'h0000_0000;
    logic [ADDR_W-1:0] ptr_lo_bound = 16'h0010, ptr_hi_bound = 16'h00FF;
    logic [3:0]        lat = 4'h0;          // memory wait states
    logic cmd_ready_q, cmd_done_q, mem_req_q, mem_we_q, mem_ack;
    logic pointer_range_flag_q, negative_flag_q, zero_load_flag_q;
    logic [ADDR_W-1:0] mem_addr_q;
    logic [WORD_W-1:0] mem_wdata_q, mem_rdata;
    logic [ACC_W-1:0]  acc_q;
    int                fails = 0, n_tests = 0, cyc = 0;
    asl_unit #(.DEPTH(DEPTH)) dut_u (.*);
    asl_mem_model mem_u (.clk(ref_clk), .req(mem_req_q), .we(mem_we_q),
        .addr(mem_addr_q), .wdata(mem_wdata_q), .lat(lat),
        .rdata(mem_rdata), .ack(mem_ack));
    always #20 ref_clk = ~ref_clk;          // 25 MHz
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // hang guard, far above the 130 or so cycles the tests need
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            close_out();
        end
    end
    task automatic chk(input logic [ACC_W-1:0] got, exp, input string what);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t %s got %h", $time, what, got);
        end
    endtask
    // one command: held until taken, then waited on under a bound
    task automatic cmd(input asl_op_e op, input asl_mode_e md,
                       input logic [ADDR_W-1:0] a, input logic [ACC_W-1:0] d);
        int n;
        n = 0;
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_mode = md;
        cmd_addr = a;
        cmd_data = d;
        while (cmd_ready_q !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        while (cmd_done_q !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        chk(ACC_W'(cmd_done_q), 32'h1, "command done");
    endtask
    task automatic scan();
        @(negedge ref_clk);
        scan_end = 1'b1;
        @(negedge ref_clk);
        scan_end = 1'b0;
    endtask
    task automatic t_scan();
        cmd(OP_RESULT, MODE_IMM, 16'h0000, 32'hC000_0000);
        chk(acc_q, 32'hC000_0000, "result");
        chk(ACC_W'(negative_flag_q), 32'h1, "negative");
        scan();
        chk(acc_q, 32'h0000_0000, "scan clear");
        $display("scan test finished");
    endtask
    task automatic t_word();
        cmd(OP_LOAD_WORD, MODE_IMM, 16'h0000, 32'hFFFF_ABCD);
        chk(acc_q, 32'h0000_ABCD, "word load");
        cmd(OP_LOAD_WORD, MODE_IMM, 16'h0000, 32'h1234_0000);
        chk(ACC_W'(zero_load_flag_q), 32'h1, "zero flag");
        cmd(OP_POP, MODE_IMM, 16'h0000, 32'h0000_0000);
        chk(acc_q, 32'h0000_ABCD, "pushed word");
        $display("word test finished");
    endtask
    task automatic t_stack();
        scan();
        for (int i = 1; i <= DEPTH + 2; i++)
            cmd(OP_LOAD_WORD, MODE_IMM, 16'h0000, ACC_W'(i));
        for (int i = DEPTH + 1; i >= 2; i--) begin
            cmd(OP_POP, MODE_IMM, 16'h0000, 32'h0000_0000);
            chk(acc_q, ACC_W'(i), "pop order");
        end
        cmd(OP_POP, MODE_IMM, 16'h0000, 32'h0000_0000);
        chk(acc_q, 32'h0000_0000, "bottom lost");
        $display("stack test finished");
    endtask
    task automatic t_store();
        scan();
        cmd(OP_LOAD_WORD, MODE_IMM, 16'h0000, 32'h5);
        cmd(OP_LOAD_WORD, MODE_IMM, 16'h0000, 32'h6);
        cmd(OP_STORE_WORD, MODE_DIR, 16'h0050, 32'h0);
        chk(ACC_W'(mem_u.mem[8'h50]), 32'h6, "store word");
        cmd(OP_LOAD_WORD, MODE_IMM, 16'h0000, 32'h7);
        cmd(OP_POP, MODE_IMM, 16'h0000, 32'h0);
        chk(acc_q, 32'h5, "no push after store");
        $display("store test finished");
    endtask
    task automatic t_double();
        lat = 4'h3;
        mem_u.mem[8'h20] = 16'h1234;
        mem_u.mem[8'h21] = 16'h8765;
        scan();
        cmd(OP_LOAD_DOUBLE, MODE_DIR, 16'h0020, 32'h0);
        chk(acc_q, 32'h8765_1234, "double load");
        cmd(OP_STORE_DOUBLE, MODE_DIR, 16'h0030, 32'h0);
        chk({mem_u.mem[8'h31], mem_u.mem[8'h30]}, 32'h8765_1234,
            "double store");
        lat = 4'h0;
        $display("double test finished");
    endtask
    task automatic t_ptr();
        mem_u.mem[8'h40] = 16'h0041;
        mem_u.mem[8'h41] = 16'h2635;
        mem_u.mem[8'h42] = 16'h0400;
        mem_u.mem[8'h43] = 16'h00FF;
        mem_u.mem[8'hFF] = 16'h0007;
        scan();
        cmd(OP_LOAD_WORD, MODE_PTR, 16'h0040, 32'h0);
        chk(acc_q, 32'h0000_2635, "pointer load");
        cmd(OP_LOAD_WORD, MODE_PTR, 16'h0042, 32'h0);
        chk(acc_q, 32'h0000_2635, "range abandon");
        chk(ACC_W'(pointer_range_flag_q), 32'h1, "range on");
        cmd(OP_LOAD_WORD, MODE_PTR, 16'h0043, 32'h0);
        chk(acc_q, 32'h0000_0007, "upper bound");
        cmd(OP_LOAD_WORD, MODE_PTR, 16'h0050, 32'h0);
        chk(ACC_W'(pointer_range_flag_q), 32'h1, "lo");
        cmd(OP_LOAD_OCTAL_ADDR, MODE_IMM, 16'h0000, 32'h0004_0400);
        chk(acc_q, 32'h0000_4100, "octal");
        cmd(OP_LOAD_OCTAL_ADDR, MODE_IMM, 16'h0000, 32'h0077_7777);
        chk(acc_q, 32'h0003_FFFF, "octal max");
        $display("pointer test finished");
    endtask
    initial begin
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        t_scan();
        t_word();
        t_stack();
        t_store();
        t_double();
        t_ptr();
        close_out();
    end
endmodule

bind asl_unit asl_unit_chk #(.DEPTH(DEPTH)) chk_u (.*);
